/* lvr_pkg.sv */
// Purpose: shared constants and types for the low-voltage reset sequencer
// Assumes: 10 MHz system clock
// Notes: control bits reach the block as plain ports, no register bus
package lvr_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // settle time that software must wait between the two enables, in us
  localparam int unsigned DETECTOR_SETTLE_TIME_US = 50;
  localparam int unsigned DETECTOR_SETTLE_CYCLES =
    (DETECTOR_SETTLE_TIME_US * (CLK_HZ / 1000000));
  // release delay after supply recovery, in system clock cycles
  localparam int unsigned RELEASE_CYCLES = 131072;
  localparam int unsigned CNT_W = 18;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic THR_SEL_RST = 1'h0;
  // values the output flops take on power-on reset
  localparam logic RESET_N_RST = 1'h1;
  localparam logic CLEAR_RST = 1'h0;
  localparam logic ACTIVE_RST = 1'h0;

  // control bits as held in the control register
  typedef struct packed {
    logic detect_power_enable;
    logic threshold_select;
    logic low_voltage_reset_enable;
  } low_voltage_control_reg_t;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_ARMED,
    ST_LOW,
    ST_RELEASE
  } lvr_state_t;
endpackage

/* lvr_sync.sv */
// Purpose: two-stage synchroniser for the comparator output
// Assumes: single clock domain on the capture side
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module lvr_sync
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  // next values of both stages
  always_comb
  begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  // reset to "supply good" so no false reset at start-up
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= 1'h0;
      sync_r <= 1'h0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule

/* low_voltage_reset_sequencer.sv */
// Purpose: low-voltage reset sequencer with timed release
// Assumes: rst_n_i is the power-on reset; comparator is asynchronous
// Notes: low-voltage reset never clears the control bits
//   threshold_select is only stored; the analog threshold sits outside
//   the release count is a parameter so simulation can shorten it
//   enable order and settle wait are software's duty, not checked here
`timescale 1ns/1ps
module low_voltage_reset_sequencer
#(
  parameter int unsigned RELEASE_COUNT = lvr_pkg::RELEASE_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic ctrl_we_i,
  input wire lvr_pkg::low_voltage_control_reg_t ctrl_wdata_i,
  output lvr_pkg::low_voltage_control_reg_t ctrl_o,
  output logic low_voltage_reset_n_o,
  output logic prescaler_clear_o,
  output logic unit_active_o
);
  import lvr_pkg::*;

  // control bits
  low_voltage_control_reg_t ctrl_r;
  low_voltage_control_reg_t ctrl_nxt;
  // sequencer state and release counter
  lvr_state_t state_r;
  lvr_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  // registered outputs
  logic rst_n_r;
  logic rst_n_nxt;
  logic clr_r;
  logic clr_nxt;
  logic act_r;
  logic act_nxt;
  // synchronised supply flag and enable decode
  logic low_s;
  logic armed;

  // last count value of the release delay
  function automatic logic [CNT_W-1:0] last_count(input int unsigned n);
    last_count = CNT_W'(n - 1);
  endfunction

  // worked out once so the compare is a plain constant
  localparam logic [CNT_W-1:0] LAST_CNT = last_count(RELEASE_COUNT);

  lvr_sync u_sync
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(supply_low_i),
    .sync_o(low_s)
  );

  // control bits only change on software writes
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (ctrl_we_i)
    begin
      ctrl_nxt = ctrl_wdata_i;
    end
  end

  // order is software's duty; both bits must be set to arm
  assign armed = ctrl_r.detect_power_enable &
                 ctrl_r.low_voltage_reset_enable;

  // sequencer next state
  // standby: nothing happens until both enable bits are set
  // armed: a synchronised low supply starts the reset
  // low: reset and prescaler clear held, enables ignored
  // release: counts recovery cycles, a new drop restarts
  // disarm takes effect only from armed or at the end of release,
  // so a reset in progress always runs to the end of its release count
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      ST_STANDBY:
      begin
        if (armed)
        begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED:
      begin
        if (!armed)
        begin
          state_nxt = ST_STANDBY;
        end
        else if (low_s)
        begin
          state_nxt = ST_LOW;
        end
      end
      ST_LOW:
      begin
        cnt_nxt = '0;
        if (!low_s)
        begin
          state_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        if (low_s)
        begin
          state_nxt = ST_LOW;
          cnt_nxt = '0;
        end
        else if (cnt_r == LAST_CNT)
        begin
          state_nxt = armed ? ST_ARMED : ST_STANDBY;
          cnt_nxt = '0;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    endcase
  end

  // outputs registered from the next state, so the ports need no decode
  always_comb
  begin
    rst_n_nxt = 1'h1;
    clr_nxt = 1'h0;
    act_nxt = 1'h1;
    unique case (state_nxt)
      ST_STANDBY:
      begin
        act_nxt = 1'h0;
      end
      ST_ARMED:
      begin
        act_nxt = 1'h1;
      end
      ST_LOW:
      begin
        rst_n_nxt = 1'h0;
        clr_nxt = 1'h1;
      end
      ST_RELEASE:
      begin
        rst_n_nxt = 1'h0;
      end
    endcase
  end

  // control bits: only power-on reset initialises them
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= low_voltage_control_reg_t'(CTRL_RST);
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // sequencer state and release counter
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_STANDBY;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // output flops; power-on reset releases the internal reset at once
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rst_n_r <= RESET_N_RST;
      clr_r <= CLEAR_RST;
      act_r <= ACTIVE_RST;
    end
    else
    begin
      rst_n_r <= rst_n_nxt;
      clr_r <= clr_nxt;
      act_r <= act_nxt;
    end
  end

  // ports straight from flops, no logic after the registers
  assign ctrl_o = ctrl_r;
  assign low_voltage_reset_n_o = rst_n_r;
  assign prescaler_clear_o = clr_r;
  assign unit_active_o = act_r;
endmodule

/* lvr_checker_sva.sv */
// Purpose: assertions on the sequencer ports
// Assumes: one clock, synchronous power-on reset
// Notes: release count follows the parameter
`timescale 1ns/1ps
module lvr_checker
#(
  parameter int unsigned RELEASE_COUNT = lvr_pkg::RELEASE_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic ctrl_we_i,
  input wire lvr_pkg::low_voltage_control_reg_t ctrl_wdata_i,
  input wire lvr_pkg::low_voltage_control_reg_t ctrl_o,
  input wire logic low_voltage_reset_n_o,
  input wire logic prescaler_clear_o,
  input wire logic unit_active_o
);
  int cnt_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // cycles since the release count began
  always_ff @(posedge clk_sys_i)
    cnt_r <= (prescaler_clear_o | low_voltage_reset_n_o) ? 0 : cnt_r + 1;
  // supply drop seen while armed and running
  sequence s_drop;
    $rose(supply_low_i) && unit_active_o && low_voltage_reset_n_o;
  endsequence
  AST_ARM: assert property ($rose(unit_active_o) |->
    ctrl_o.detect_power_enable && ctrl_o.low_voltage_reset_enable)
    else $error("active without both enables");
  AST_LOW: assert property (s_drop |-> ##3
    (!low_voltage_reset_n_o && prescaler_clear_o))
    else $error("reset not asserted on low supply");
  AST_HOLD: assert property (prescaler_clear_o |=>
    !low_voltage_reset_n_o)
    else $error("reset withdrawn early");
  AST_REL: assert property ($rose(low_voltage_reset_n_o) |->
    cnt_r == RELEASE_COUNT)
    else $error("release count wrong");
  AST_CTRL: assert property (!ctrl_we_i |=> $stable(ctrl_o))
    else $error("control bits changed without write");
  AST_SYNC: assert property (s_drop |-> low_voltage_reset_n_o [*3])
    else $error("reset ahead of synchroniser");
  cover property ($rose(low_voltage_reset_n_o));
  cover property ($fell(low_voltage_reset_n_o));
  cover property ($rose(unit_active_o));
endmodule
bind low_voltage_reset_sequencer lvr_checker
  #(.RELEASE_COUNT(RELEASE_COUNT)) u_chk
  (.clk_sys_i, .rst_n_i, .supply_low_i, .ctrl_we_i, .ctrl_wdata_i, .ctrl_o,
   .low_voltage_reset_n_o, .prescaler_clear_o, .unit_active_o);

/* low_voltage_reset_sequencer_tb_top.sv */
// Purpose: self-checking bench for the sequencer
// Assumes: release count cut to 16 for run time
// Notes: inputs change on falling edges
`timescale 1ns/1ps
module low_voltage_reset_sequencer_tb_top;
  import lvr_pkg::*;
  localparam int RC = 16;
  logic clk_sys_i = 1'h0, rst_n_i = 1'h0, supply_low_i = 1'h0;
  logic ctrl_we_i = 1'h0;
  low_voltage_control_reg_t ctrl_wdata_i = 3'h0, ctrl_o;
  logic low_voltage_reset_n_o, prescaler_clear_o, unit_active_o;
  int failures = 0, compares = 0;
  // 100 ns period
  always #50 clk_sys_i = ~clk_sys_i;
  low_voltage_reset_sequencer #(.RELEASE_COUNT(RC)) DUT
  (.clk_sys_i, .rst_n_i, .supply_low_i, .ctrl_we_i, .ctrl_wdata_i, .ctrl_o,
   .low_voltage_reset_n_o, .prescaler_clear_o, .unit_active_o);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [2:0] v);
    ctrl_we_i = 1'h1;
    ctrl_wdata_i = v;
    cyc(1);
    ctrl_we_i = 1'h0;
    cyc(1);
  endtask
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_arm;
    chk(8'(unit_active_o), 8'h0);
    wr(3'h4);
    cyc(DETECTOR_SETTLE_CYCLES);
    chk(8'(unit_active_o), 8'h0);
    wr(3'h7);
    cyc(3); // port setup after enable
    chk(8'(unit_active_o), 8'h1);
    $display("arm test done");
  endtask
  task automatic t_low;
    int n;
    n = 0;
    supply_low_i = 1'h1;
    cyc(2);
    chk(8'(low_voltage_reset_n_o), 8'h1);
    cyc(2);
    chk({6'h0, low_voltage_reset_n_o, prescaler_clear_o}, 8'h1);
    cyc(40);
    chk({5'h0, ctrl_o}, 8'h7);
    supply_low_i = 1'h0;
    // bounded wait for the release
    while (low_voltage_reset_n_o !== 1'h1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    if (n == 100)
    begin
      failures++;
    end
    chk(8'(n), 8'(RC + 3));
    chk({5'h0, ctrl_o}, 8'h7);
    $display("low supply test done");
  endtask
  task automatic t_por;
    supply_low_i = 1'h1;
    cyc(5);
    rst_n_i = 1'h0;
    cyc(2);
    rst_n_i = 1'h1;
    supply_low_i = 1'h0;
    cyc(1);
    chk({4'h0, ctrl_o, low_voltage_reset_n_o}, 8'h1);
    $display("power-on test done");
  endtask
  initial
  begin
    cyc(2);
    rst_n_i = 1'h1;
    t_arm();
    t_low();
    wr(3'h6);
    wr(3'h2);
    t_arm();
    t_por();
    conclude();
  end
endmodule
